//--- hw/vrc_vector_control.sv
`timescale 1ns/1ns
`include "vrc_defs.svh"
module vrc_vector_control (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Instruction issue
  input wire logic issue_valid_in,
  input wire vrc_pkg::vrc_issue_s issue_in,
  input wire logic [7:0] element_count_register_in,
  input wire logic [31:0] memory_base_address_register_in,
  input wire logic [31:0] memory_stride_register_in,
  output logic issue_accept_out,
  // Element to scalar result
  output logic scalar_valid_out,
  output logic [63:0] scalar_data_out,
  // Functional units
  output logic [1:0] fu_busy_out,
  output logic [1:0] fu_req_valid_out,
  output vrc_pkg::vrc_fu_req_s [1:0] fu_req_out,
  input wire logic [1:0] fu_res_valid_in,
  input wire vrc_pkg::vrc_pair_s [1:0] fu_res_data_in,
  // Memory port
  input wire logic mem_conflict_in,
  output logic mem_req_valid_out,
  output vrc_pkg::vrc_mem_req_s mem_req_out,
  input wire logic mem_load_valid_in,
  input wire vrc_pkg::vrc_pair_s mem_load_data_in
);
  localparam int NFU = `VRC_NFU;
  localparam int NV = `VRC_NVREG;
  localparam int SW = $bits(vrc_pkg::vrc_st_word_s);
  localparam logic [3:0] DEPTH = 4'(`VRC_FIFO_DEPTH);

  // Functional unit slots
  logic fu_act_reg [NFU];
  logic [2:0] fu_dst_reg [NFU];
  logic [2:0] fu_j_reg [NFU];
  logic [2:0] fu_k_reg [NFU];
  logic fu_usek_reg [NFU];
  logic [7:0] fu_len_reg [NFU];
  logic [7:0] fu_rd_reg [NFU];
  logic [7:0] fu_wr_reg [NFU];
  logic [63:0] fu_scal_reg [NFU];
  logic fu_p1_reg [NFU];
  logic [1:0] fu_p1cnt_reg [NFU];
  logic fu_go [NFU];
  logic [7:0] fu_rd_end [NFU];
  logic [7:0] fu_wr_end [NFU];

  // Memory port slot
  vrc_pkg::vrc_mem_state_e ms_reg;
  logic [2:0] ms_vreg_reg;
  logic [7:0] ms_len_reg;
  logic [7:0] ms_rd_reg;
  logic [7:0] ms_wr_reg;
  logic [31:0] ms_addr_reg;
  logic [31:0] ms_stride_reg;
  logic st_p1_reg;
  logic [1:0] st_p1cnt_reg;
  logic st_go;
  logic [7:0] ms_rd_end;
  logic [7:0] ms_wr_end;

  // Element to scalar path
  logic v2s_p1_reg;
  logic v2s_odd_reg;

  // Reservation state per vector register
  logic [7:0] wcnt_reg [NV];
  logic [NV-1:0] res_busy;
  logic [NV-1:0] op_busy;

  // Issue decode
  logic take;
  logic ok;
  logic [7:0] len_in;

  // Register file and store buffer wiring
  logic [`VRC_NWR-1:0][1:0] wr_en;
  logic [`VRC_NWR-1:0][8:0] wr_addr;
  vrc_pkg::vrc_pair_s [`VRC_NWR-1:0] wr_data;
  logic [`VRC_NRD-1:0][8:0] rd_addr;
  vrc_pkg::vrc_pair_s [`VRC_NRD-1:0] rd_data;
  vrc_pkg::vrc_st_word_s st_in;
  vrc_pkg::vrc_st_word_s st_out;
  logic st_in_ready;
  logic st_out_valid;
  logic st_out_ready;
  logic [3:0] st_count;

  // End of the next pair, clipped to the length
  function automatic logic [7:0] pair_end(input logic [7:0] idx,
                                          input logic [7:0] len);
    logic [7:0] nxt;
    nxt = idx + `VRC_PAIR_STEP;
    pair_end = (nxt > len) ? len : nxt;
  endfunction : pair_end

  // Source elements up to need are present, or own result
  function automatic logic src_ok(input logic [2:0] v,
                                  input logic [7:0] need,
                                  input logic self);
    src_ok = !res_busy[v] || self || (wcnt_reg[v] >= need);
  endfunction : src_ok

  // Reservations derived from the active slots
  always_comb begin
    res_busy = '0;
    op_busy = '0;
    for (int u = 0; u < NFU; u++) begin
      if (fu_act_reg[u]) res_busy[fu_dst_reg[u]] = 1'b1;
      if (fu_act_reg[u] && fu_rd_reg[u] < fu_len_reg[u]) begin
        op_busy[fu_j_reg[u]] = 1'b1;
        if (fu_usek_reg[u]) op_busy[fu_k_reg[u]] = 1'b1;
      end
    end
    if (ms_reg == vrc_pkg::VRC_MS_LOAD) res_busy[ms_vreg_reg] = 1'b1;
    if (ms_reg == vrc_pkg::VRC_MS_STORE && ms_rd_reg < ms_len_reg)
      op_busy[ms_vreg_reg] = 1'b1;
  end

  // Operand reads gated by chaining progress
  always_comb begin
    for (int u = 0; u < NFU; u++) begin
      fu_rd_end[u] = pair_end(fu_rd_reg[u], fu_len_reg[u]);
      fu_wr_end[u] = pair_end(fu_wr_reg[u], fu_len_reg[u]);
      fu_go[u] = fu_act_reg[u] && fu_rd_reg[u] < fu_len_reg[u]
        && src_ok(fu_j_reg[u], fu_rd_end[u],
                  fu_j_reg[u] == fu_dst_reg[u])
        && (!fu_usek_reg[u] || src_ok(fu_k_reg[u], fu_rd_end[u],
                  fu_k_reg[u] == fu_dst_reg[u]));
    end
    ms_rd_end = pair_end(ms_rd_reg, ms_len_reg);
    ms_wr_end = pair_end(ms_wr_reg, ms_len_reg);
    st_go = ms_reg == vrc_pkg::VRC_MS_STORE && ms_rd_reg < ms_len_reg
      && src_ok(ms_vreg_reg, ms_rd_end, 1'b0)
      && st_in_ready && (st_count + 4'(st_p1_reg) < DEPTH);
  end

  // Hazard checks at issue
  always_comb begin
    len_in = (element_count_register_in > `VRC_CNT_MAX) ?
      `VRC_CNT_MAX : element_count_register_in;
    ok = 1'b0;
    unique case (issue_in.op)
      vrc_pkg::VRC_OP_FU:
        ok = !fu_act_reg[issue_in.unit]
          && !op_busy[issue_in.vj]
          && (issue_in.use_scalar || !op_busy[issue_in.vk])
          && !op_busy[issue_in.vi] && !res_busy[issue_in.vi];
      vrc_pkg::VRC_OP_LOAD, vrc_pkg::VRC_OP_S2V:
        ok = ms_reg == vrc_pkg::VRC_MS_IDLE
          && !op_busy[issue_in.vi] && !res_busy[issue_in.vi];
      vrc_pkg::VRC_OP_STORE:
        ok = ms_reg == vrc_pkg::VRC_MS_IDLE && !op_busy[issue_in.vj];
      vrc_pkg::VRC_OP_V2S:
        ok = ms_reg == vrc_pkg::VRC_MS_IDLE && !v2s_p1_reg
          && !op_busy[issue_in.vj] && !res_busy[issue_in.vj];
      default: ok = 1'b0;
    endcase
    take = issue_valid_in && !issue_accept_out && ok;
  end

  // Register file port addressing
  always_comb begin
    for (int u = 0; u < NFU; u++) begin
      // Pair index selects element 2n in even bank, 2n+1 in odd
      rd_addr[2*u] = {fu_j_reg[u], fu_rd_reg[u][6:1]};
      rd_addr[2*u+1] = {fu_k_reg[u], fu_rd_reg[u][6:1]};
      wr_en[u][0] = fu_res_valid_in[u] && fu_act_reg[u];
      wr_en[u][1] = wr_en[u][0] && (fu_wr_end[u] - fu_wr_reg[u] == 8'h02);
      wr_addr[u] = {fu_dst_reg[u], fu_wr_reg[u][6:1]};
      wr_data[u] = fu_res_data_in[u];
    end
    rd_addr[`VRC_RD_MEM] = (ms_reg == vrc_pkg::VRC_MS_STORE) ?
      {ms_vreg_reg, ms_rd_reg[6:1]} : {issue_in.vj, issue_in.elem[6:1]};
    wr_en[`VRC_WR_MEM] = 2'h0;
    wr_addr[`VRC_WR_MEM] = {ms_vreg_reg, ms_wr_reg[6:1]};
    wr_data[`VRC_WR_MEM] = mem_load_data_in;
    if (ms_reg == vrc_pkg::VRC_MS_LOAD && mem_load_valid_in) begin
      wr_en[`VRC_WR_MEM] = {ms_wr_end - ms_wr_reg == 8'h02, 1'b1};
    end else if (take && issue_in.op == vrc_pkg::VRC_OP_S2V) begin
      wr_en[`VRC_WR_MEM] = {issue_in.elem[0], !issue_in.elem[0]};
      wr_addr[`VRC_WR_MEM] = {issue_in.vi, issue_in.elem[6:1]};
      wr_data[`VRC_WR_MEM] = '{odd: issue_in.scalar, even: issue_in.scalar};
    end
  end

  // Store words enter the buffer as reads land
  assign st_in.cnt = st_p1cnt_reg;
  assign st_in.data = rd_data[`VRC_RD_MEM];
  assign st_out_ready = ms_reg == vrc_pkg::VRC_MS_STORE
    && !mem_conflict_in;

  vrc_vreg_mem u_vreg_mem (
    .clock_in(clock_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .rd_addr_in(rd_addr),
    .rd_data_out(rd_data)
  );

  vrc_fifo #(.WIDTH(SW), .DEPTH(`VRC_FIFO_DEPTH)) u_store_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(st_p1_reg),
    .in_ready_out(st_in_ready),
    .in_data_in(st_in),
    .out_valid_out(st_out_valid),
    .out_ready_in(st_out_ready),
    .out_data_out(st_out),
    .count_out(st_count)
  );

  // Functional unit slots: issue, operand stream, result stream
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int u = 0; u < NFU; u++) begin
        fu_act_reg[u] <= 1'b0;
        fu_dst_reg[u] <= 3'h0;
        fu_j_reg[u] <= 3'h0;
        fu_k_reg[u] <= 3'h0;
        fu_usek_reg[u] <= 1'b0;
        fu_len_reg[u] <= 8'h00;
        fu_rd_reg[u] <= 8'h00;
        fu_wr_reg[u] <= 8'h00;
        fu_scal_reg[u] <= 64'h0;
        fu_p1_reg[u] <= 1'b0;
        fu_p1cnt_reg[u] <= 2'h0;
      end
    end else begin
      for (int u = 0; u < NFU; u++) begin
        fu_p1_reg[u] <= fu_go[u];
        fu_p1cnt_reg[u] <= 2'(fu_rd_end[u] - fu_rd_reg[u]);
        if (fu_go[u]) fu_rd_reg[u] <= fu_rd_end[u];
        if (wr_en[u][0]) begin
          fu_wr_reg[u] <= fu_wr_end[u];
          if (fu_wr_end[u] == fu_len_reg[u]) fu_act_reg[u] <= 1'b0;
        end
        if (take && issue_in.op == vrc_pkg::VRC_OP_FU
            && issue_in.unit == 1'(u)) begin
          fu_act_reg[u] <= (len_in != 8'h00);
          fu_dst_reg[u] <= issue_in.vi;
          fu_j_reg[u] <= issue_in.vj;
          fu_k_reg[u] <= issue_in.vk;
          fu_usek_reg[u] <= !issue_in.use_scalar;
          fu_len_reg[u] <= len_in;
          fu_rd_reg[u] <= `VRC_ELEM_FIRST;
          fu_wr_reg[u] <= `VRC_ELEM_FIRST;
          fu_scal_reg[u] <= issue_in.scalar;
        end
      end
    end
  end

  // Results written so far per register, for chaining
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int v = 0; v < NV; v++) wcnt_reg[v] <= 8'h00;
    end else begin
      for (int u = 0; u < NFU; u++)
        if (wr_en[u][0]) wcnt_reg[fu_dst_reg[u]] <= fu_wr_end[u];
      if (ms_reg == vrc_pkg::VRC_MS_LOAD && mem_load_valid_in)
        wcnt_reg[ms_vreg_reg] <= ms_wr_end;
      if (take && (issue_in.op == vrc_pkg::VRC_OP_FU
                   || issue_in.op == vrc_pkg::VRC_OP_LOAD))
        wcnt_reg[issue_in.vi] <= 8'h00;
    end
  end

  // Memory port slot: strided load and store sequencing
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ms_reg <= vrc_pkg::VRC_MS_IDLE;
      ms_vreg_reg <= 3'h0;
      ms_len_reg <= 8'h00;
      ms_rd_reg <= 8'h00;
      ms_wr_reg <= 8'h00;
      ms_addr_reg <= 32'h0;
      ms_stride_reg <= 32'h0;
      st_p1_reg <= 1'b0;
      st_p1cnt_reg <= 2'h0;
    end else begin
      st_p1_reg <= st_go;
      st_p1cnt_reg <= 2'(ms_rd_end - ms_rd_reg);
      unique case (ms_reg)
        vrc_pkg::VRC_MS_IDLE: begin
          if (take && len_in != 8'h00
              && (issue_in.op == vrc_pkg::VRC_OP_LOAD
                  || issue_in.op == vrc_pkg::VRC_OP_STORE)) begin
            ms_reg <= (issue_in.op == vrc_pkg::VRC_OP_LOAD) ?
              vrc_pkg::VRC_MS_LOAD : vrc_pkg::VRC_MS_STORE;
            ms_vreg_reg <= (issue_in.op == vrc_pkg::VRC_OP_LOAD) ?
              issue_in.vi : issue_in.vj;
            ms_len_reg <= len_in;
            ms_rd_reg <= `VRC_ELEM_FIRST;
            ms_wr_reg <= `VRC_ELEM_FIRST;
            ms_addr_reg <= memory_base_address_register_in;
            ms_stride_reg <= memory_stride_register_in;
          end
        end
        vrc_pkg::VRC_MS_LOAD: begin
          if (ms_rd_reg < ms_len_reg && !mem_conflict_in) begin
            ms_rd_reg <= ms_rd_end;
            ms_addr_reg <= ms_addr_reg + {ms_stride_reg[30:0], 1'b0};
          end
          if (mem_load_valid_in) begin
            ms_wr_reg <= ms_wr_end;
            if (ms_wr_end == ms_len_reg) ms_reg <= vrc_pkg::VRC_MS_IDLE;
          end
        end
        vrc_pkg::VRC_MS_STORE: begin
          if (st_go) ms_rd_reg <= ms_rd_end;
          if (st_out_valid && st_out_ready) begin
            ms_addr_reg <= ms_addr_reg + {ms_stride_reg[30:0], 1'b0};
            ms_wr_reg <= ms_wr_reg + 8'(st_out.cnt);
            if (ms_wr_reg + 8'(st_out.cnt) == ms_len_reg)
              ms_reg <= vrc_pkg::VRC_MS_IDLE;
          end
        end
        default: ms_reg <= vrc_pkg::VRC_MS_IDLE;
      endcase
    end
  end

  // Memory port requests, two words at most per cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mem_req_valid_out <= 1'b0;
      mem_req_out <= '0;
    end else begin
      mem_req_valid_out <= 1'b0;
      mem_req_out.addr_even <= ms_addr_reg;
      mem_req_out.addr_odd <= ms_addr_reg + ms_stride_reg;
      if (ms_reg == vrc_pkg::VRC_MS_LOAD && ms_rd_reg < ms_len_reg
          && !mem_conflict_in) begin
        mem_req_valid_out <= 1'b1;
        mem_req_out.write <= 1'b0;
        mem_req_out.cnt <= 2'(ms_rd_end - ms_rd_reg);
      end else if (st_out_valid && st_out_ready) begin
        mem_req_valid_out <= 1'b1;
        mem_req_out.write <= 1'b1;
        mem_req_out.cnt <= st_out.cnt;
        mem_req_out.data <= st_out.data;
      end
    end
  end

  // Operand pairs to the functional units
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fu_req_valid_out <= 2'h0;
      fu_req_out <= '0;
      fu_busy_out <= 2'h0;
    end else begin
      for (int u = 0; u < NFU; u++) begin
        fu_req_valid_out[u] <= fu_p1_reg[u];
        fu_req_out[u].a <= rd_data[2*u];
        fu_req_out[u].b <= rd_data[2*u+1];
        fu_req_out[u].s <= fu_scal_reg[u];
        fu_req_out[u].cnt <= fu_p1cnt_reg[u];
        fu_busy_out[u] <= fu_act_reg[u];
      end
    end
  end

  // Issue acknowledge and element to scalar transfer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      issue_accept_out <= 1'b0;
      v2s_p1_reg <= 1'b0;
      v2s_odd_reg <= 1'b0;
      scalar_valid_out <= 1'b0;
      scalar_data_out <= 64'h0;
    end else begin
      issue_accept_out <= take;
      v2s_p1_reg <= take && issue_in.op == vrc_pkg::VRC_OP_V2S;
      v2s_odd_reg <= issue_in.elem[0];
      scalar_valid_out <= v2s_p1_reg;
      if (v2s_p1_reg) begin
        scalar_data_out <= v2s_odd_reg ? rd_data[`VRC_RD_MEM].odd
          : rd_data[`VRC_RD_MEM].even;
      end
    end
  end
endmodule : vrc_vector_control

//--- pkg/vrc_defs.svh
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH
`define VRC_NVREG 8
`define VRC_NFU 2
`define VRC_NRD 5
`define VRC_NWR 3
`define VRC_RD_MEM 4
`define VRC_WR_MEM 2
`define VRC_FIFO_DEPTH 8
`define VRC_WORD 64
`define VRC_ADDR 32
`define VRC_ELEM_FIRST 8'h00
`define VRC_CNT_MAX 8'h80
`define VRC_PAIR_STEP 8'h02
`endif

//--- pkg/vrc_pkg.sv
package vrc_pkg;
  // Instruction kinds
  typedef enum logic [2:0] {
    VRC_OP_FU = 3'h0,
    VRC_OP_LOAD = 3'h1,
    VRC_OP_STORE = 3'h2,
    VRC_OP_S2V = 3'h3,
    VRC_OP_V2S = 3'h4
  } vrc_op_e;
  // Memory port slot state
  typedef enum logic [1:0] {
    VRC_MS_IDLE = 2'h0,
    VRC_MS_LOAD = 2'h1,
    VRC_MS_STORE = 2'h2
  } vrc_mem_state_e;
  // Even and odd element words
  typedef struct packed {
    logic [63:0] odd;
    logic [63:0] even;
  } vrc_pair_s;
  // Issued instruction
  typedef struct packed {
    vrc_op_e op;
    logic unit;
    logic [2:0] vi;
    logic [2:0] vj;
    logic [2:0] vk;
    logic use_scalar;
    logic [6:0] elem;
    logic [63:0] scalar;
  } vrc_issue_s;
  // Operand pair to a functional unit
  typedef struct packed {
    vrc_pair_s a;
    vrc_pair_s b;
    logic [63:0] s;
    logic [1:0] cnt;
  } vrc_fu_req_s;
  // Store word in the buffer
  typedef struct packed {
    logic [1:0] cnt;
    vrc_pair_s data;
  } vrc_st_word_s;
  // Memory port request
  typedef struct packed {
    logic write;
    logic [1:0] cnt;
    logic [31:0] addr_even;
    logic [31:0] addr_odd;
    vrc_pair_s data;
  } vrc_mem_req_s;
endpackage : vrc_pkg

//--- hw/vrc_fifo.sv
`timescale 1ns/1ns
module vrc_fifo #(
  parameter int WIDTH = 130,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  // Handshakes and occupancy
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = store_reg[rp_reg];
  assign count_out = count_reg;
  always_comb begin
    count_next = count_reg;
    if (push && !pop) count_next = count_reg + 1'b1;
    if (pop && !push) count_next = count_reg - 1'b1;
  end

  // Pointers, count and registered ready
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b1;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      count_reg <= count_next;
      in_ready_out <= (count_next != FULL);
    end
  end

  // Storage
  always_ff @(posedge clock_in) begin
    if (push) store_reg[wp_reg] <= in_data_in;
  end
endmodule : vrc_fifo

//--- hw/vrc_vreg_mem.sv
`timescale 1ns/1ns
`include "vrc_defs.svh"
module vrc_vreg_mem (
  // Clock
  input wire logic clock_in,
  // Write ports, bit 0 even, bit 1 odd
  input wire logic [`VRC_NWR-1:0][1:0] wr_en_in,
  input wire logic [`VRC_NWR-1:0][8:0] wr_addr_in,
  input wire vrc_pkg::vrc_pair_s [`VRC_NWR-1:0] wr_data_in,
  // Read ports, one cycle latency
  input wire logic [`VRC_NRD-1:0][8:0] rd_addr_in,
  output vrc_pkg::vrc_pair_s [`VRC_NRD-1:0] rd_data_out
);
  logic [63:0] bank_even [512];
  logic [63:0] bank_odd [512];

  // Even bank and odd bank written per element
  always_ff @(posedge clock_in) begin
    for (int w = 0; w < `VRC_NWR; w++) begin
      if (wr_en_in[w][0]) bank_even[wr_addr_in[w]] <= wr_data_in[w].even;
      if (wr_en_in[w][1]) bank_odd[wr_addr_in[w]] <= wr_data_in[w].odd;
    end
  end

  // Registered read ports
  for (genvar r = 0; r < `VRC_NRD; r++) begin : g_rd
    vrc_pkg::vrc_pair_s rd_reg;
    always_ff @(posedge clock_in) begin
      rd_reg.even <= bank_even[rd_addr_in[r]];
      rd_reg.odd <= bank_odd[rd_addr_in[r]];
    end
    assign rd_data_out[r] = rd_reg;
  end
endmodule : vrc_vreg_mem

//--- testbench/vrc_monitor.sv
`timescale 1ns/1ns
module vrc_monitor (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic issue_valid_in,
  input wire logic issue_accept_out,
  input wire logic scalar_valid_out,
  input wire logic [1:0] fu_busy_out,
  input wire logic [1:0] fu_req_valid_out,
  input wire vrc_pkg::vrc_fu_req_s [1:0] fu_req_out,
  input wire logic mem_conflict_in,
  input wire logic mem_req_valid_out,
  input wire vrc_pkg::vrc_mem_req_s mem_req_out
);
  // One domain for all checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // Accept answers a held request, one cycle wide
  property p_acc;
    issue_accept_out |-> $past(issue_valid_in) ##1 !issue_accept_out;
  endproperty
  a_acc: assert property (p_acc) else $error("accept not a pulse");
  // Element word follows its accept
  property p_scal;
    scalar_valid_out |-> $past(issue_accept_out);
  endproperty
  a_scal: assert property (p_scal) else $error("scalar late");
  // At most two words per cycle
  property p_mcnt;
    mem_req_valid_out |-> mem_req_out.cnt inside {2'h1, 2'h2};
  endproperty
  a_mcnt: assert property (p_mcnt) else $error("bad mem cnt");
  // First unit pair count
  property p_fcnt0;
    fu_req_valid_out[0] |-> fu_req_out[0].cnt inside {2'h1, 2'h2};
  endproperty
  a_fcnt0: assert property (p_fcnt0) else $error("bad fu0 cnt");
  // Second unit pair count
  property p_fcnt1;
    fu_req_valid_out[1] |-> fu_req_out[1].cnt inside {2'h1, 2'h2};
  endproperty
  a_fcnt1: assert property (p_fcnt1) else $error("bad fu1 cnt");
  // Next pair steps by twice the stride
  property p_strd;
    mem_req_valid_out && !mem_req_out.write && $past(mem_req_valid_out)
      && !$past(mem_req_out.write) && $past(mem_req_out.cnt) == 2'h2
      |-> mem_req_out.addr_even - $past(mem_req_out.addr_odd) ==
      $past(mem_req_out.addr_odd) - $past(mem_req_out.addr_even);
  endproperty
  a_strd: assert property (p_strd) else $error("bad stride");
  // Conflict holds back load requests
  property p_conf;
    mem_req_valid_out && !mem_req_out.write |-> !$past(mem_conflict_in);
  endproperty
  a_conf: assert property (p_conf) else $error("load in conflict");
  // Unit requests only from a reserved unit
  property p_idle;
    (fu_req_valid_out & ~$past(fu_busy_out)) == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle unit fed");
endmodule : vrc_monitor

bind vrc_vector_control vrc_monitor i_vrc_monitor (.*);

//--- testbench/vrc_partner.sv
`timescale 1ns/1ns
module vrc_partner (
  // Clock, reset, pace
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic slow_in,
  // Functional units
  input wire logic [1:0] fu_req_valid_out,
  input wire vrc_pkg::vrc_fu_req_s [1:0] fu_req_out,
  output logic [1:0] fu_res_valid_in,
  output vrc_pkg::vrc_pair_s [1:0] fu_res_data_in,
  // Memory port
  input wire logic mem_req_valid_out,
  input wire vrc_pkg::vrc_mem_req_s mem_req_out,
  output logic mem_load_valid_in,
  output vrc_pkg::vrc_pair_s mem_load_data_in
);
  logic [2:0][1:0] v_reg;
  vrc_pkg::vrc_pair_s [2:0][1:0] d_reg;
  int wr_n;
  vrc_pkg::vrc_mem_req_s wr_q;
  // Three stage adders of both pairs and the scalar, one lane per unit
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      v_reg <= '0;
      d_reg <= '0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        d_reg[0][u].even <= fu_req_out[u].a.even + fu_req_out[u].b.even
          + fu_req_out[u].s;
        d_reg[0][u].odd <= fu_req_out[u].a.odd + fu_req_out[u].b.odd
          + fu_req_out[u].s;
      end
      v_reg <= {v_reg[1:0], fu_req_valid_out};
      d_reg[2:1] <= d_reg[1:0];
    end
  end
  // Prompt or slow result delivery
  assign fu_res_valid_in = slow_in ? v_reg[2] : v_reg[0];
  assign fu_res_data_in = slow_in ? d_reg[2] : d_reg[0];
  // Memory returns the address as data; idle data toggles
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mem_load_valid_in <= 1'b0;
      mem_load_data_in <= '0;
      wr_n <= 0;
      wr_q <= '0;
    end else begin
      mem_load_valid_in <= mem_req_valid_out & ~mem_req_out.write;
      if (mem_req_valid_out & ~mem_req_out.write) begin
        mem_load_data_in <= {32'h0, mem_req_out.addr_odd, 32'h0,
          mem_req_out.addr_even};
      end else begin
        mem_load_data_in <= ~mem_load_data_in;
      end
      if (mem_req_valid_out & mem_req_out.write) begin
        wr_n <= wr_n + 1;
        wr_q <= mem_req_out;
      end
    end
  end
endmodule : vrc_partner

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic issue_valid_in = 1'b0;
  logic mem_conflict_in = 1'b0;
  logic slow_in = 1'b0;
  vrc_pkg::vrc_issue_s issue_in = '0;
  logic [7:0] element_count_register_in = 8'h00;
  logic [31:0] memory_base_address_register_in = 32'h0;
  logic [31:0] memory_stride_register_in = 32'h0;
  logic issue_accept_out, scalar_valid_out, mem_req_valid_out;
  logic mem_load_valid_in;
  logic [63:0] scalar_data_out;
  logic [1:0] fu_busy_out, fu_req_valid_out, fu_res_valid_in;
  vrc_pkg::vrc_fu_req_s [1:0] fu_req_out;
  vrc_pkg::vrc_pair_s [1:0] fu_res_data_in;
  vrc_pkg::vrc_mem_req_s mem_req_out;
  vrc_pkg::vrc_pair_s mem_load_data_in;
  int err_count = 0;
  int cmp_count = 0;
  // Clock and parts
  always #25 clock_in = ~clock_in;
  vrc_vector_control i_vrc_vector_control (.*);
  vrc_partner i_vrc_partner (.*);
  // Move to just after the next edge
  task automatic step;
    @(posedge clock_in);
    #5;
  endtask : step
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d failed", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 200) begin
      err_count++;
      $display("FAIL wait expected done seen timeout");
      print_verdict();
    end
  endtask : tmo
  // Issue one instruction, then disturb the sampled registers
  task automatic iss(input vrc_pkg::vrc_op_e op, input logic u,
    input logic [2:0] vi, vj, vk, input logic [6:0] el,
    input logic [63:0] sc, input logic [7:0] n, input logic [31:0] b, s);
    int k;
    // Nonzero scalar on a unit op selects the scalar operand
    issue_in = '{op, u, vi, vj, vk,
      op == vrc_pkg::VRC_OP_FU && sc != 64'h0, el, sc};
    element_count_register_in = n;
    memory_base_address_register_in = b;
    memory_stride_register_in = s;
    issue_valid_in = 1'b1;
    for (k = 0; k < 200 && issue_accept_out !== 1'b1; k++) step();
    tmo(k);
    issue_valid_in = 1'b0;
    element_count_register_in = ~n;
    issue_in.scalar = ~sc;
    memory_base_address_register_in = ~b;
    memory_stride_register_in = ~s;
    step();
  endtask : iss
  // Read one element through the scalar path
  task automatic rdv(input logic [2:0] vj, input logic [6:0] el,
    input logic [63:0] e);
    int k;
    iss(vrc_pkg::VRC_OP_V2S, 1'b0, 3'h0, vj, 3'h0, el, 64'h0, 8'h01,
      32'h0, 32'h0);
    for (k = 0; k < 200 && scalar_valid_out !== 1'b1; k++) step();
    tmo(k);
    chk("scalar_data_out", e, scalar_data_out);
  endtask : rdv
  task automatic t_load;
    iss(vrc_pkg::VRC_OP_LOAD, 1'b0, 3'h0, 3'h0, 3'h0, 7'h00, 64'h0,
      8'h08, 32'h100, 32'h3);
    rdv(3'h0, 7'h00, 64'h100);
    rdv(3'h0, 7'h04, 64'h10C);
    $display("t_load done");
  endtask : t_load
  // Load stalled by conflict, two units chained behind it
  task automatic t_chain;
    slow_in = 1'b1;
    mem_conflict_in = 1'b1;
    iss(vrc_pkg::VRC_OP_LOAD, 1'b0, 3'h1, 3'h0, 3'h0, 7'h00, 64'h0,
      8'h08, 32'h200, 32'h1);
    iss(vrc_pkg::VRC_OP_FU, 1'b0, 3'h2, 3'h0, 3'h1, 7'h00, 64'h0,
      8'h08, 32'h0, 32'h0);
    iss(vrc_pkg::VRC_OP_FU, 1'b1, 3'h3, 3'h2, 3'h2, 7'h00, 64'h0,
      8'h08, 32'h0, 32'h0);
    step();
    mem_conflict_in = 1'b0;
    rdv(3'h3, 7'h07, 64'h638);
    rdv(3'h2, 7'h01, 64'h304);
    slow_in = 1'b0;
    $display("t_chain done");
  endtask : t_chain
  // Same register read and written, scalar operand added
  task automatic t_self;
    iss(vrc_pkg::VRC_OP_FU, 1'b0, 3'h0, 3'h0, 3'h0, 7'h00, 64'h10,
      8'h02, 32'h0, 32'h0);
    chk("fu_busy_out", 64'h1, 64'(fu_busy_out));
    rdv(3'h0, 7'h01, 64'h216);
    chk("fu_busy_out", 64'h0, 64'(fu_busy_out));
    $display("t_self done");
  endtask : t_self
  task automatic t_s2v;
    iss(vrc_pkg::VRC_OP_S2V, 1'b0, 3'h4, 3'h0, 3'h0, 7'h7F,
      64'hFEDC_BA98_7654_3210, 8'h01, 32'h0, 32'h0);
    rdv(3'h4, 7'h7F, 64'hFEDC_BA98_7654_3210);
    $display("t_s2v done");
  endtask : t_s2v
  // Odd length store with a negative stride
  task automatic t_store;
    int k;
    iss(vrc_pkg::VRC_OP_STORE, 1'b0, 3'h0, 3'h0, 3'h0, 7'h00, 64'h0,
      8'h03, 32'h40, 32'hFFFF_FFFF);
    for (k = 0; k < 200 && i_vrc_partner.wr_n < 2; k++) step();
    tmo(k);
    repeat (6) step();
    chk("writes", 64'h2, 64'(i_vrc_partner.wr_n));
    chk("last cnt", 64'h1, 64'(i_vrc_partner.wr_q.cnt));
    chk("last addr", 64'h3E, 64'(i_vrc_partner.wr_q.addr_even));
    chk("last data", 64'h106, i_vrc_partner.wr_q.data.even);
    $display("t_store done");
  endtask : t_store
  initial begin
    repeat (4) @(posedge clock_in);
    #5;
    rst_in = 1'b0;
    step();
    t_load();
    t_chain();
    t_self();
    t_s2v();
    t_store();
    print_verdict();
  end
endmodule : testbench
